// file: core/sif_pkg.sv
// Package with register map, field positions, reset values and codes of the status flag block.
package sif_pkg;
    // Register byte offsets on the Avalon-MM slave.
    localparam logic [5:0] SIF_OFS_MASTER_CMD  = 6'h0c;
    localparam logic [5:0] SIF_OFS_XFER_STATUS = 6'h10;
    localparam logic [5:0] SIF_OFS_RAW_IRQ     = 6'h30;
    localparam logic [5:0] SIF_OFS_IRQ_CLEAR   = 6'h38;
    // Raw status bit positions.
    localparam int SIF_BIT_RD_SLV  = 16;
    localparam int SIF_BIT_WR_SLV  = 18;
    localparam int SIF_BIT_ARB     = 24;
    localparam int SIF_BIT_BUS_ERR = 25;
    localparam int SIF_BIT_DWS     = 28;
    // Master command fields.
    localparam int SIF_CMD_READ    = 0;
    localparam int SIF_CMD_ADDR_LO = 1;
    localparam int SIF_CMD_STOP    = 8;
    localparam int SIF_CMD_LEN_LO  = 9;
    // Error tags of the transaction status word, error_tag_a field in bits 3:0.
    localparam logic [3:0] SIF_TAG_NONE    = 4'h0;
    localparam logic [3:0] SIF_TAG_ARB     = 4'h1;
    localparam logic [3:0] SIF_TAG_BUS_ERR = 4'h2;
    localparam logic [3:0] SIF_TAG_DONE    = 4'h3;
    localparam int SIF_SR_OP_BIT = 4;
    // Reset values.
    localparam logic [31:0] SIF_RST_WORD = 32'h0000_0000;
    localparam logic [1:0]  SIF_RST_PIN  = 2'h3;
    // Master sequencer states.
    typedef enum logic [1:0] {
        SIF_ST_IDLE,
        SIF_ST_RUN,
        SIF_ST_WAIT_STOP
    } sif_state_type;
endpackage

// file: core/sif_pin_sync.sv
// Three-stage pin synchroniser that passes a change once stages two and three agree.
`timescale 1ns/1ps
module sif_pin_sync
    import sif_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_sync_n,
    input  wire logic [1:0] i_pin,
    output logic      [1:0] o_level
);
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] level;
    } sif_sync_type;

    sif_sync_type st_reg;
    sif_sync_type st_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Stage one feeds stage two only; the filter looks at stages two and three.
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = i_pin;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < 2; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.level[i] = st_reg.s3[i];
            end
        end
    end

    // Open-drain lines idle high, so all stages reset high.
    always_ff @(posedge i_core_clk or negedge i_rst_sync_n) begin
        if (!i_rst_sync_n) begin
            st_reg <= '{s1: SIF_RST_PIN, s2: SIF_RST_PIN, s3: SIF_RST_PIN, level: SIF_RST_PIN};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_level = st_reg.level;
endmodule

// file: core/sif_status_flags.sv
// Upper raw status flags of the two-wire controller with master sequencing and slave hold-off.
// Summary of operation
// - An unexpected start or stop seen during a transaction sets the bus fault flag, bit 25.
// - Writing a one to bit 25 or 28 of the clear register drops that raw status bit.
// - A master operation that ends without a programmed stop sets bit 28 and no stop is sent.
// - A new master command is taken only once the done-without-stop flag is clear.
// - While bit 28 is set, slave requests are held back and the clock line is kept low while one waits.
// - On lost arbitration the master stops, frees the bus, waits for a stop, then retries.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module sif_status_flags
    import sif_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    // Avalon-MM slave.
    input  wire logic [5:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic [3:0]  i_byteenable,
    output logic      [31:0] o_readdata,
    output logic             o_waitrequest,
    // Two-wire pins, open drain; the output value is always low.
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_scl_o,
    output logic             o_scl_oe,
    output logic             o_sda_o,
    output logic             o_sda_oe,
    // Bit engine, same clock.
    input  wire logic        i_eng_done,
    input  wire logic        i_eng_cond,
    input  wire logic        i_eng_sda_out,
    input  wire logic        i_eng_scl_low,
    input  wire logic        i_slv_wr_req,
    input  wire logic        i_slv_rd_req,
    output logic             o_eng_start,
    output logic             o_eng_abort,
    output logic             o_eng_read,
    output logic      [6:0]  o_eng_addr,
    output logic      [6:0]  o_eng_len,
    output logic             o_eng_stop
);
    typedef struct packed {
        sif_state_type state;
        logic [15:0]   cmd;
        logic [31:0]   raw;
        logic [31:0]   xfer_status;
        logic          wr_pend;
        logic          rd_pend;
        logic [1:0]    pin_prev;
        logic          ack;
        logic [31:0]   rdata;
        logic          start;
        logic          abort;
    } sif_core_type;

    sif_core_type st_reg;
    sif_core_type st_next;
    logic [1:0]   rst_sync_reg;
    logic [1:0]   pin_level;
    logic         scl_now;
    logic         sda_now;
    logic         start_seen;
    logic         stop_seen;
    logic         scl_rise;
    logic         req;
    logic         bus_we;
    logic [31:0]  clr;
    logic [31:0]  set;

    // Expands byte enables into a bit mask for writes.
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    // Selects a register for a given offset.
    function automatic logic hit(input logic [5:0] addr, input logic [5:0] ofs);
        return addr == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops; assertion stays asynchronous.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    sif_pin_sync u_pin_sync (
        .i_core_clk   (i_core_clk),
        .i_rst_sync_n (rst_sync_reg[1]),
        .i_pin        ({i_scl, i_sda}),
        .o_level      (pin_level)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus condition detection on the filtered lines.
    assign scl_now    = pin_level[1];
    assign sda_now    = pin_level[0];
    assign start_seen = scl_now && st_reg.pin_prev[1] && st_reg.pin_prev[0] && !sda_now;
    assign stop_seen  = scl_now && st_reg.pin_prev[1] && !st_reg.pin_prev[0] && sda_now;
    assign scl_rise   = scl_now && !st_reg.pin_prev[1];

    // Bus access completes one cycle after it is first seen, so readdata is a flop.
    assign req           = i_read || i_write;
    assign o_waitrequest = req && !st_reg.ack;
    assign bus_we        = i_write && st_reg.ack;
    assign clr           = (bus_we && hit(i_address, SIF_OFS_IRQ_CLEAR))
                           ? (i_writedata & be_mask(i_byteenable)) : 32'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Master sequencing, flag setting and register access.
    always_comb begin
        st_next          = st_reg;
        set              = 32'h0;
        st_next.pin_prev = pin_level;
        st_next.start    = 1'b0;
        st_next.abort    = 1'b0;
        st_next.ack      = req && !st_reg.ack;

        // Slave requests are latched and only surfaced once the flag is clear.
        if (i_slv_wr_req) begin
            st_next.wr_pend = 1'b1;
        end
        if (i_slv_rd_req) begin
            st_next.rd_pend = 1'b1;
        end

        unique case (st_reg.state)
            SIF_ST_IDLE: begin
                // Commands arriving while the flag is set are dropped, not queued.
                if (bus_we && hit(i_address, SIF_OFS_MASTER_CMD)
                    && !st_reg.raw[SIF_BIT_DWS]) begin
                    st_next.cmd   = i_writedata[15:0];
                    st_next.start = 1'b1;
                    st_next.state = SIF_ST_RUN;
                end
            end
            SIF_ST_RUN: begin
                if ((start_seen || stop_seen) && !i_eng_cond) begin
                    set[SIF_BIT_BUS_ERR] = 1'b1;
                    st_next.xfer_status  = {27'h0, st_reg.cmd[SIF_CMD_READ],
                                            SIF_TAG_BUS_ERR};
                    st_next.abort        = 1'b1;
                    st_next.state        = SIF_ST_IDLE;
                end else if (scl_rise && i_eng_sda_out && !sda_now) begin
                    // Read a zero while sending a one: back off and retry later.
                    set[SIF_BIT_ARB]    = 1'b1;
                    st_next.xfer_status = {27'h0, st_reg.cmd[SIF_CMD_READ], SIF_TAG_ARB};
                    st_next.abort       = 1'b1;
                    st_next.state       = SIF_ST_WAIT_STOP;
                end else if (i_eng_done) begin
                    st_next.xfer_status = {27'h0, st_reg.cmd[SIF_CMD_READ], SIF_TAG_DONE};
                    if (!st_reg.cmd[SIF_CMD_STOP]) begin
                        set[SIF_BIT_DWS] = 1'b1;
                    end
                    st_next.state = SIF_ST_IDLE;
                end
            end
            SIF_ST_WAIT_STOP: begin
                if (stop_seen) begin
                    st_next.start = 1'b1;
                    st_next.state = SIF_ST_RUN;
                end
            end
        endcase

        // Deferred slave notification.
        if (!st_reg.raw[SIF_BIT_DWS]) begin
            set[SIF_BIT_WR_SLV] = st_reg.wr_pend;
            set[SIF_BIT_RD_SLV] = st_reg.rd_pend;
            st_next.wr_pend     = i_slv_wr_req;
            st_next.rd_pend     = i_slv_rd_req;
        end

        // A set in the same cycle as its clear wins; writes to raw status are ignored.
        st_next.raw = ((st_reg.raw & ~clr) | set) & {3'h0, 1'b1, 2'h0, 2'h3, 5'h0, 1'b1, 1'b0,
                                                      1'b1, 16'h0};

        // Read data captured in the first cycle of an access; unmapped reads give zero.
        st_next.rdata = 32'h0;
        if (i_read && !st_reg.ack) begin
            if (hit(i_address, SIF_OFS_RAW_IRQ)) begin
                st_next.rdata = st_reg.raw;
            end else if (hit(i_address, SIF_OFS_XFER_STATUS)) begin
                st_next.rdata = st_reg.xfer_status;
            end else if (hit(i_address, SIF_OFS_MASTER_CMD)) begin
                st_next.rdata = {16'h0, st_reg.cmd};
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_sync_reg[1]) begin
        if (!rst_sync_reg[1]) begin
            st_reg <= '{state: SIF_ST_IDLE, cmd: 16'h0, raw: SIF_RST_WORD,
                        xfer_status: SIF_RST_WORD, wr_pend: 1'b0, rd_pend: 1'b0,
                        pin_prev: SIF_RST_PIN, ack: 1'b0, rdata: SIF_RST_WORD,
                        start: 1'b0, abort: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs. The clock is stretched while a slave request waits behind the flag.
    assign o_readdata  = st_reg.rdata;
    assign o_scl_o     = 1'b0;
    assign o_sda_o     = 1'b0;
    assign o_scl_oe    = i_eng_scl_low || ((st_reg.wr_pend || st_reg.rd_pend)
                         && st_reg.raw[SIF_BIT_DWS]);
    // After a loss the data line is released at once, not a bit later.
    assign o_sda_oe    = (st_reg.state == SIF_ST_RUN) && !i_eng_sda_out
                         && !(scl_rise && !sda_now && i_eng_sda_out);
    assign o_eng_start = st_reg.start;
    assign o_eng_abort = st_reg.abort;
    assign o_eng_read  = st_reg.cmd[SIF_CMD_READ];
    assign o_eng_addr  = st_reg.cmd[SIF_CMD_ADDR_LO +: 7];
    assign o_eng_len   = st_reg.cmd[SIF_CMD_LEN_LO +: 7];
    assign o_eng_stop  = st_reg.cmd[SIF_CMD_STOP];
endmodule

// file: testbench/sif_status_props.sv
// Checker for handshake, pulse and pin relations at the status flag block ports.
`timescale 1ns/1ps
module sif_status_props (
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic        i_read,
    input wire logic        i_write,
    input wire logic [31:0] o_readdata,
    input wire logic        o_waitrequest,
    input wire logic        i_eng_scl_low,
    input wire logic        o_scl_o,
    input wire logic        o_scl_oe,
    input wire logic        o_sda_o,
    input wire logic        o_eng_start,
    input wire logic        o_eng_abort
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    //////////////////////////////////////////////////////////////////////////////////////////
    // A request waits exactly one cycle, and data appear only in its answer cycle.
    sequence s_req_wait;
        (i_read || i_write) && o_waitrequest;
    endsequence
    sequence s_answer;
        i_read && !o_waitrequest && $past(i_read);
    endsequence
    property p_one_wait;
        s_req_wait |=> !o_waitrequest;
    endproperty
    property p_idle_nowait;
        !(i_read || i_write) |-> !o_waitrequest;
    endproperty
    property p_wait_zero;
        o_waitrequest |-> o_readdata == 32'h0;
    endproperty
    property p_data_window;
        o_readdata != 32'h0 |-> s_answer;
    endproperty
    // Engine pulses last one cycle; an abort is never followed at once by a restart.
    property p_start_pulse;
        o_eng_start |=> !o_eng_start;
    endproperty
    property p_abort_hold;
        o_eng_abort |=> !o_eng_start [*2];
    endproperty
    property p_start_no_abort;
        o_eng_start |-> !o_eng_abort;
    endproperty
    // Open-drain pins only ever pull low, and the engine's clock pull always reaches SCL.
    property p_od_low;
        o_scl_o == 1'b0 && o_sda_o == 1'b0;
    endproperty
    property p_scl_follow;
        i_eng_scl_low |-> o_scl_oe;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
    a_idle_nowait: assert property (p_idle_nowait) else $error("wait without request");
    a_wait_zero: assert property (p_wait_zero) else $error("data during wait");
    a_data_window: assert property (p_data_window) else $error("data outside answer");
    a_start_pulse: assert property (p_start_pulse) else $error("start too long");
    a_abort_hold: assert property (p_abort_hold) else $error("restart after abort");
    a_start_no_abort: assert property (p_start_no_abort) else $error("start with abort");
    a_od_low: assert property (p_od_low) else $error("pin output driven high");
    a_scl_follow: assert property (p_scl_follow) else $error("clock pull lost");
endmodule
bind sif_status_flags sif_status_props u_props (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_eng_scl_low(i_eng_scl_low), .o_scl_o(o_scl_o),
    .o_scl_oe(o_scl_oe), .o_sda_o(o_sda_o), .o_eng_start(o_eng_start),
    .o_eng_abort(o_eng_abort));

// file: testbench/sif_bus_peer.sv
// Other stations on the two wires, joined with the block through pull-ups.
`timescale 1ns/1ps
module sif_bus_peer (
    input  wire logic i_scl_oe,
    input  wire logic i_sda_oe,
    input  wire logic i_hold_scl,
    input  wire logic i_hold_sda,
    output logic      o_scl,
    output logic      o_sda
);
    // A released line rises to the pull-up level, so no stale value is left on it.
    assign o_scl = !(i_scl_oe || i_hold_scl);
    assign o_sda = !(i_sda_oe || i_hold_sda);
endmodule

// file: testbench/tb_top.sv
// Bench for the upper raw status flags with register tasks, engine stimulus and bus peer.
`timescale 1ns/1ps
module tb_top;
    import sif_pkg::*;
    logic        clk, rst_n, rd, wr, done, swr, srd, scl_low, sda_out, hscl, hsda, wreq;
    logic        scl, sda, scl_oe, sda_oe, start, abort, stop, cond, eng_read;
    logic [5:0]  addr;
    logic [6:0]  eng_addr, eng_len;
    logic [31:0] wdata, rdata, q;
    int          error_cnt = 0, tests_run = 0, starts = 0, aborts = 0;
    sif_status_flags DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_address(addr), .i_read(rd),
        .i_write(wr), .i_writedata(wdata), .i_byteenable(4'hf), .o_readdata(rdata),
        .o_waitrequest(wreq), .i_scl(scl), .i_sda(sda), .o_scl_o(), .o_scl_oe(scl_oe),
        .o_sda_o(), .o_sda_oe(sda_oe), .i_eng_done(done), .i_eng_cond(cond),
        .i_eng_sda_out(sda_out), .i_eng_scl_low(scl_low), .i_slv_wr_req(swr),
        .i_slv_rd_req(srd), .o_eng_start(start), .o_eng_abort(abort), .o_eng_read(eng_read),
        .o_eng_addr(eng_addr), .o_eng_len(eng_len), .o_eng_stop(stop));
    sif_bus_peer u_peer (.i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .i_hold_scl(hscl),
        .i_hold_sda(hsda), .o_scl(scl), .o_sda(sda));
    //////////////////////////////////////////////////////////////////////////////////////////
    // Clock, a watchdog well beyond the run length, and engine pulse counters at mid-cycle.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end
    always @(negedge clk) begin
        starts += (start === 1'b1);
        aborts += (abort === 1'b1);
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    // One Avalon transfer; the request stands until waitrequest is sampled low at a rising edge.
    // Right after an edge the design still shows the values settled before it, so the edge
    // that sees waitrequest low is also the one at which read data are taken.
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rchk(input string s, input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(s, e, q);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Pulse one of done, slave write request, slave read request for one cycle.
    task automatic pulse(input int k);
        @(posedge clk);
        {done, swr, srd} <= 3'h4 >> k;
        @(posedge clk);
        {done, swr, srd} <= 3'h0;
    endtask
    //////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence; the engine keeps SDA released so only the peer makes conditions, up to the engine's own start and stop at the end.
    initial begin
        {rd, wr, done, swr, srd, scl_low, hscl, hsda, cond} = 9'h0;
        sda_out = 1'b1;
        addr = 6'h0;
        wdata = 32'h0;
        rst_n = 1'b0;
        cyc(3);
        rst_n <= 1'b1;
        cyc(10);
        scl_low <= 1'b1;
        cyc(2);
        scl_low <= 1'b0;
        rchk("raw reset", SIF_OFS_RAW_IRQ, SIF_RST_WORD);
        bus(1'b1, SIF_OFS_RAW_IRQ, 32'hffff_ffff);
        rchk("raw after write", SIF_OFS_RAW_IRQ, 32'h0);
        rchk("unmapped", 6'h3c, 32'h0);
        // A start seen mid-transfer is a bus fault with its own tag and an abort.
        bus(1'b1, SIF_OFS_MASTER_CMD, 32'h0000_0154);
        cyc(3);
        chk("starts", 32'h1, starts);
        chk("addr", 32'h2a, eng_addr);
        hsda <= 1'b1;
        cyc(8);
        rchk("raw fault", SIF_OFS_RAW_IRQ, 32'h1 << SIF_BIT_BUS_ERR);
        rchk("tag fault", SIF_OFS_XFER_STATUS, {28'h0, SIF_TAG_BUS_ERR});
        chk("aborts", 32'h1, aborts);
        hsda <= 1'b0;
        cyc(8);
        bus(1'b1, SIF_OFS_IRQ_CLEAR, 32'h1 << SIF_BIT_BUS_ERR);
        rchk("fault cleared", SIF_OFS_RAW_IRQ, 32'h0);
        // Arbitration lost on a clock rise; the same command restarts after a stop.
        bus(1'b1, SIF_OFS_MASTER_CMD, 32'h0000_0154);
        hscl <= 1'b1;
        cyc(8);
        hsda <= 1'b1;
        cyc(8);
        hscl <= 1'b0;
        cyc(8);
        chk("arb abort", 32'h2, aborts);
        chk("no early retry", 32'h2, starts);
        hsda <= 1'b0;
        cyc(8);
        chk("retry", 32'h3, starts);
        rchk("tag arb", SIF_OFS_XFER_STATUS, {28'h0, SIF_TAG_ARB});
        pulse(0);
        cyc(3);
        rchk("raw arb", SIF_OFS_RAW_IRQ, 32'h1 << SIF_BIT_ARB);
        bus(1'b1, SIF_OFS_IRQ_CLEAR, 32'h1 << SIF_BIT_ARB);
        // Done without stop holds off commands and slave requests until cleared.
        bus(1'b1, SIF_OFS_MASTER_CMD, 32'h0000_0054);
        cyc(3);
        chk("stop field", 32'h0, stop);
        pulse(0);
        cyc(3);
        rchk("raw dws", SIF_OFS_RAW_IRQ, 32'h1 << SIF_BIT_DWS);
        rchk("tag done", SIF_OFS_XFER_STATUS, {28'h0, SIF_TAG_DONE});
        bus(1'b1, SIF_OFS_MASTER_CMD, 32'h0000_0154);
        cyc(3);
        chk("cmd refused", 32'h4, starts);
        pulse(1);
        cyc(3);
        rchk("slave held", SIF_OFS_RAW_IRQ, 32'h1 << SIF_BIT_DWS);
        chk("scl stretched", 32'h0, scl);
        bus(1'b1, SIF_OFS_IRQ_CLEAR, 32'h1 << SIF_BIT_DWS);
        rchk("slave notified", SIF_OFS_RAW_IRQ, 32'h1 << SIF_BIT_WR_SLV);
        chk("scl freed", 32'h0, scl_oe);
        bus(1'b1, SIF_OFS_IRQ_CLEAR, 32'h1 << SIF_BIT_WR_SLV);
        pulse(2);
        cyc(2);
        rchk("slave read", SIF_OFS_RAW_IRQ, 32'h1 << SIF_BIT_RD_SLV);
        // Read command to address 0x2a, length 5, with stop: the read and length fields reach the engine.
        bus(1'b1, SIF_OFS_MASTER_CMD, 32'h0000_0b55);
        cyc(3);
        chk("cmd taken", 32'h5, starts);
        chk("read field", 32'h1, eng_read);
        chk("len field", 32'h5, eng_len);
        // A start and a stop that the engine makes itself are no bus fault.
        cond <= 1'b1;
        sda_out <= 1'b0;
        cyc(8);
        chk("sda pulled", 32'h1, sda_oe);
        sda_out <= 1'b1;
        cyc(8);
        cond <= 1'b0;
        rchk("own conditions", SIF_OFS_RAW_IRQ, 32'h1 << SIF_BIT_RD_SLV);
        pulse(0);
        cyc(3);
        rchk("tag read", SIF_OFS_XFER_STATUS, {27'h0, 1'b1, SIF_TAG_DONE});
        finish_test();
    end
endmodule
